// file: design/bsf_ctrl.sv
// bsf_ctrl: front panel programming and function button control
// assumes operator buttons on raw pins and a software side that starts
// address downloads and update requests
//
// Summary of operation
// [RULE_01] each program press toggles programming mode
// [RULE_02] programming mode lights led seven red
// [RULE_03] new address stored only in programming mode
// [RULE_04] default node address is 15.15.255
// [RULE_05] three second function hold starts linkage reset
// [RULE_06] led two orange during linkage reset
// [RULE_07] led two green back in normal operation
// [RULE_08] operator holds fifteen then three seconds
// [RULE_09] leds one and two orange awaiting press
// [RULE_10] second press restores defaults and restarts
// [RULE_11] operator authorises update with short press; the code takes a short function press only in programming mode
// [RULE_12] debounce buttons; abandon factory reset on timeout
// [RULE_13] boot mode blinks led two green
`timescale 1ns/1ps
module bsf_ctrl #(
    parameter int unsigned DB_CYC      = bsf_pkg::DEBOUNCE_CYC,    // button settle time
    parameter int unsigned SHORT_CYC   = bsf_pkg::SHORT_HOLD_CYC,  // 3 s hold
    parameter int unsigned LONG_CYC    = bsf_pkg::LONG_HOLD_CYC,   // 15 s hold
    parameter int unsigned TIMEOUT_CYC = bsf_pkg::FR_TIMEOUT_CYC,  // second press wait
    parameter int unsigned LINK_CYC    = bsf_pkg::LINK_RST_CYC,    // disconnect time
    parameter int unsigned BLINKH_CYC  = bsf_pkg::BLINK_CYC        // blink half period
) (
    // clock, reset, enable
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               ce,
    // raw buttons, active high
    input  wire logic               prog_btn,
    input  wire logic               func_btn,
    // address download from the configuration side
    input  wire logic               dl_active,
    input  wire bsf_pkg::bsf_addr_t dl_addr,
    // update request from the web side
    input  wire logic               update_req,
    input  wire logic               update_done,
    // status outputs
    output bsf_pkg::bsf_addr_t      node_address,
    output logic                    prog_mode,
    output logic                    link_reset,
    output logic                    factory_reset,
    output logic                    restart,
    output logic                    boot_mode,
    output bsf_pkg::bsf_leds_t      leds
);
    import bsf_pkg::*;

    // hold-time threshold compare
    function automatic logic reached(input logic [CNT_W-1:0] c, input int unsigned lim);
        reached = (c >= CNT_W'(lim - 1));
    endfunction

    logic             prog_lvl;       // clean program button
    logic             func_lvl;       // clean function button
    logic             prog_q_r;       // delayed copies for edges
    logic             func_q_r;
    bsf_state_t       st_r;
    bsf_state_t       st_nxt;
    logic [CNT_W-1:0] hold_r;         // function hold time
    logic [CNT_W-1:0] hold_nxt;
    logic [CNT_W-1:0] tmr_r;          // state timer
    logic [CNT_W-1:0] tmr_nxt;
    logic             pm_r;
    logic             pm_nxt;
    logic             auth_r;         // update authorised
    logic             auth_nxt;
    logic             blink_r;
    logic             blink_nxt;
    logic             rs_r;
    logic             rs_nxt;
    bsf_addr_t        na_r;
    bsf_addr_t        na_nxt;
    bsf_leds_t        leds_r;
    bsf_leds_t        leds_nxt;
    logic [2:0]       flags_r;        // link, factory, boot state flags
    logic [2:0]       flags_nxt;
    logic             prog_rise;
    logic             func_fall;

    ////////////////////////////////////////////////////////////////////////
    // button conditioning
    bsf_debounce #(.SETTLE_CYC(DB_CYC)) u_prog_db (             // RULE_12
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .pin      (prog_btn),
        .level    (prog_lvl)
    );
    bsf_debounce #(.SETTLE_CYC(DB_CYC)) u_func_db (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .pin      (func_btn),
        .level    (func_lvl)
    );

    assign prog_rise = prog_lvl & ~prog_q_r;
    assign func_fall = ~func_lvl & func_q_r;

    ////////////////////////////////////////////////////////////////////////
    // next state of the special function machine
    always_comb begin
        st_nxt    = st_r;
        hold_nxt  = func_lvl ? hold_r + CNT_W'(~&hold_r) : '0;  // saturates, no wrap
        tmr_nxt   = tmr_r + 1'b1;
        pm_nxt    = pm_r;
        auth_nxt  = auth_r;
        blink_nxt = blink_r;
        rs_nxt    = 1'b0;
        na_nxt    = na_r;
        // program button press flips the mode
        if (prog_rise) begin
            pm_nxt = ~pm_r;                                    // RULE_01
            if (pm_r && dl_active) begin
                na_nxt = dl_addr;                              // RULE_03
            end
        end
        case (st_r)
            BSF_NORMAL: begin
                tmr_nxt = '0;
                if (func_fall) begin
                    // release decides which function the hold meant
                    if (reached(hold_r, LONG_CYC)) begin
                        st_nxt = BSF_FR_WAIT;                  // RULE_09
                    end else if (reached(hold_r, SHORT_CYC)) begin
                        st_nxt = BSF_LINK_RST;                 // RULE_05
                    end else if (pm_r) begin
                        auth_nxt = 1'b1;
                    end
                end
                if (auth_r && update_req) begin
                    st_nxt   = BSF_BOOT;                       // RULE_13
                    auth_nxt = 1'b0;
                end
            end
            BSF_LINK_RST: begin
                if (reached(tmr_r, LINK_CYC)) begin
                    st_nxt = BSF_NORMAL;                       // RULE_07
                end
            end
            BSF_FR_WAIT: begin
                if (func_fall && reached(hold_r, SHORT_CYC)) begin
                    st_nxt = BSF_FR_DO;
                end else if (!func_lvl && reached(tmr_r, TIMEOUT_CYC)) begin
                    st_nxt = BSF_NORMAL;                       // RULE_12
                end else if (func_lvl) begin
                    tmr_nxt = '0;
                end
            end
            BSF_FR_DO: begin
                na_nxt   = DEF_NODE_ADDR;                      // RULE_10
                pm_nxt   = 1'b0;
                auth_nxt = 1'b0;
                rs_nxt   = 1'b1;
                st_nxt   = BSF_NORMAL;
            end
            BSF_BOOT: begin
                if (reached(tmr_r, BLINKH_CYC)) begin
                    blink_nxt = ~blink_r;
                    tmr_nxt   = '0;
                end
                if (update_done) begin
                    rs_nxt = 1'b1;
                    st_nxt = BSF_NORMAL;
                end
            end
            default: st_nxt = BSF_NORMAL;
        endcase
        if (st_nxt != st_r) begin
            tmr_nxt = '0;
        end
        if (st_nxt != BSF_BOOT) begin
            blink_nxt = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // led display for the next state
    always_comb begin
        flags_nxt = {st_nxt == BSF_LINK_RST, st_nxt == BSF_FR_DO, st_nxt == BSF_BOOT};
        leds_nxt.led7 = pm_nxt ? BSF_LED_RED : BSF_LED_OFF;    // RULE_02
        leds_nxt.led1 = BSF_LED_GREEN;
        leds_nxt.led2 = BSF_LED_GREEN;                          // RULE_07
        case (st_nxt)
            BSF_LINK_RST: leds_nxt.led2 = BSF_LED_ORANGE;       // RULE_06
            BSF_FR_WAIT: begin
                leds_nxt.led1 = BSF_LED_ORANGE;                 // RULE_09
                leds_nxt.led2 = BSF_LED_ORANGE;
            end
            BSF_BOOT: leds_nxt.led2 = blink_nxt ? BSF_LED_GREEN : BSF_LED_OFF;
            default: leds_nxt.led2 = BSF_LED_GREEN;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r     <= BSF_NORMAL;
            hold_r   <= '0;
            tmr_r    <= '0;
            pm_r     <= 1'b0;
            auth_r   <= 1'b0;
            blink_r  <= 1'b0;
            rs_r     <= 1'b0;
            na_r     <= DEF_NODE_ADDR;                          // RULE_04
            leds_r   <= '{led1: BSF_LED_GREEN, led2: BSF_LED_GREEN, led7: BSF_LED_OFF};
            flags_r  <= 3'h0;
            prog_q_r <= 1'b0;
            func_q_r <= 1'b0;
        end else if (ce) begin
            st_r     <= st_nxt;
            hold_r   <= hold_nxt;
            tmr_r    <= tmr_nxt;
            pm_r     <= pm_nxt;
            auth_r   <= auth_nxt;
            blink_r  <= blink_nxt;
            rs_r     <= rs_nxt;
            na_r     <= na_nxt;
            leds_r   <= leds_nxt;
            flags_r  <= flags_nxt;
            prog_q_r <= prog_lvl;
            func_q_r <= func_lvl;
        end
    end

    // outputs straight from flip-flops
    assign node_address  = na_r;
    assign prog_mode     = pm_r;
    assign link_reset    = flags_r[2];
    assign factory_reset = flags_r[1];
    assign restart       = rs_r;
    assign boot_mode     = flags_r[0];
    assign leds          = leds_r;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_prog_toggle;
        @(posedge core_clk) disable iff (rst)
        (ce && prog_rise && st_r != BSF_FR_DO) |=> (pm_r != $past(pm_r));
    endproperty
    a_prog_toggle: assert property (p_prog_toggle) else $error("prog mode not toggled"); // RULE_01
    property p_led7;
        @(posedge core_clk) disable iff (rst)
        1'b1 |=> ((leds_r.led7 == BSF_LED_RED) == pm_r);
    endproperty
    a_led7: assert property (p_led7) else $error("led7 disagrees with prog mode"); // RULE_02
    property p_addr_guard;
        @(posedge core_clk) disable iff (rst)
        (ce && !pm_r && st_r != BSF_FR_DO) |=> $stable(na_r);
    endproperty
    a_addr_guard: assert property (p_addr_guard) else $error("address changed outside prog"); // RULE_03
    property p_fr_default;
        @(posedge core_clk) disable iff (rst)
        (ce && st_r == BSF_FR_DO) |=> (na_r == DEF_NODE_ADDR && rs_r && !pm_r);
    endproperty
    a_fr_default: assert property (p_fr_default) else $error("factory reset incomplete"); // RULE_10
    property p_link_start;
        @(posedge core_clk) disable iff (rst)
        (ce && st_r == BSF_NORMAL && func_fall && !reached(hold_r, SHORT_CYC))
            |=> (st_r != BSF_LINK_RST);
    endproperty
    a_link_start: assert property (p_link_start) else $error("linkage reset too early"); // RULE_05
    property p_led2_orange;
        @(posedge core_clk) disable iff (rst)
        (st_r == BSF_LINK_RST) |-> (leds_r.led2 == BSF_LED_ORANGE);
    endproperty
    a_led2_orange: assert property (p_led2_orange) else $error("led2 not orange"); // RULE_06
    property p_led2_green;
        @(posedge core_clk) disable iff (rst)
        (st_r == BSF_NORMAL) |-> (leds_r.led2 == BSF_LED_GREEN);
    endproperty
    a_led2_green: assert property (p_led2_green) else $error("led2 not green"); // RULE_07

    property p_fr_leds;
        @(posedge core_clk) disable iff (rst)
        (st_r == BSF_FR_WAIT) |-> (leds_r.led1 == BSF_LED_ORANGE && leds_r.led2 == BSF_LED_ORANGE);
    endproperty
    a_fr_leds: assert property (p_fr_leds) else $error("wait leds wrong"); // RULE_09

    property p_fr_timeout;
        @(posedge core_clk) disable iff (rst)
        (ce && st_r == BSF_FR_WAIT && !func_lvl && !func_fall && reached(tmr_r, TIMEOUT_CYC))
            |=> (st_r == BSF_NORMAL);
    endproperty
    a_fr_timeout: assert property (p_fr_timeout) else $error("timeout not taken"); // RULE_12

    property p_boot_led;
        @(posedge core_clk) disable iff (rst)
        (st_r == BSF_BOOT) |-> (leds_r.led2 != BSF_LED_ORANGE && leds_r.led2 != BSF_LED_RED);
    endproperty
    a_boot_led: assert property (p_boot_led) else $error("boot led colour wrong"); // RULE_13

    c_link:  cover property (@(posedge core_clk) st_r == BSF_LINK_RST);
    c_fr:    cover property (@(posedge core_clk) st_r == BSF_FR_DO);
    c_boot:  cover property (@(posedge core_clk) st_r == BSF_BOOT);
    c_store: cover property (@(posedge core_clk) ce && prog_rise && pm_r && dl_active);
endmodule

// file: common/bsf_pkg.sv
// bsf_pkg: constants, states and carriers for the button special function block
// assumes a 100 MHz core clock; long holds are parameters of the top module
package bsf_pkg;
    // clock rate and derived counts
    localparam int unsigned CLK_HZ          = 100_000_000;  // core clock rate in Hz
    localparam int unsigned DEBOUNCE_MS     = 20;           // debounce settle time, ms
    localparam int unsigned DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned SHORT_HOLD_S    = 3;            // linkage reset / second press, s
    localparam int unsigned LONG_HOLD_S     = 15;           // first factory reset press, s
    localparam int unsigned FR_TIMEOUT_S    = 10;           // wait limit for second press, s
    localparam int unsigned LINK_RST_MS     = 1000;         // linkage reset disconnect time, ms
    localparam int unsigned BLINK_MS        = 250;          // boot mode blink half period, ms
    localparam int unsigned SHORT_HOLD_CYC  = CLK_HZ * SHORT_HOLD_S;
    localparam int unsigned LONG_HOLD_CYC   = CLK_HZ / 10 * LONG_HOLD_S * 10;
    localparam int unsigned FR_TIMEOUT_CYC  = CLK_HZ / 10 * FR_TIMEOUT_S * 10;
    localparam int unsigned LINK_RST_CYC    = CLK_HZ / 1000 * LINK_RST_MS;
    localparam int unsigned BLINK_CYC       = CLK_HZ / 1000 * BLINK_MS;
    localparam int unsigned CNT_W           = 32;           // width of every timer

    // factory default node address 15.15.255 (area.line.device)
    localparam logic [3:0]  DEF_AREA        = 4'hf;
    localparam logic [3:0]  DEF_LINE        = 4'hf;
    localparam logic [7:0]  DEF_DEVICE      = 8'hff;

    // led colour codes
    typedef enum logic [1:0] {
        BSF_LED_OFF    = 2'h0,
        BSF_LED_GREEN  = 2'h1,
        BSF_LED_RED    = 2'h2,
        BSF_LED_ORANGE = 2'h3
    } bsf_led_t;

    // node address carrier
    typedef struct packed {
        logic [3:0] area;
        logic [3:0] line;
        logic [7:0] device;
    } bsf_addr_t;

    localparam bsf_addr_t DEF_NODE_ADDR = '{area: DEF_AREA, line: DEF_LINE, device: DEF_DEVICE};

    // front panel led carrier: leds 1, 2 and 7
    typedef struct packed {
        bsf_led_t led1;
        bsf_led_t led2;
        bsf_led_t led7;
    } bsf_leds_t;

    // special function state, gray code in the listed order
    typedef enum logic [2:0] {
        BSF_NORMAL   = 3'b000,
        BSF_LINK_RST = 3'b001,
        BSF_FR_WAIT  = 3'b011,
        BSF_FR_DO    = 3'b010,
        BSF_BOOT     = 3'b110
    } bsf_state_t;
endpackage

// file: design/bsf_debounce.sv
// bsf_debounce: three-stage synchroniser and settle filter for one button
// assumes a raw active-high pin from outside the clock domain
`timescale 1ns/1ps
module bsf_debounce #(
    parameter int unsigned SETTLE_CYC = bsf_pkg::DEBOUNCE_CYC  // settle time, cycles
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic ce,
    // raw pin and clean level
    input  wire logic pin,
    output logic      level
);
    import bsf_pkg::*;

    logic [2:0]       sync_r;   // synchroniser chain
    logic [2:0]       sync_nxt;
    logic [CNT_W-1:0] cnt_r;    // settle counter
    logic [CNT_W-1:0] cnt_nxt;
    logic             lvl_r;    // accepted level
    logic             lvl_nxt;

    ////////////////////////////////////////////////////////////////////////
    // next state: change counts once stages two and three agree
    always_comb begin
        sync_nxt = {sync_r[1:0], pin};
        cnt_nxt  = cnt_r;
        lvl_nxt  = lvl_r;
        if (sync_r[2] != sync_r[1] || sync_r[2] == lvl_r) begin
            // disagreement or no change: restart the settle wait
            cnt_nxt = '0;
        end else if (cnt_r >= CNT_W'(SETTLE_CYC - 1)) begin
            lvl_nxt = sync_r[2];
            cnt_nxt = '0;
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_r <= '0;
            cnt_r  <= '0;
            lvl_r  <= 1'b0;
        end else if (ce) begin
            sync_r <= sync_nxt;
            cnt_r  <= cnt_nxt;
            lvl_r  <= lvl_nxt;
        end
    end

    assign level = lvl_r;
endmodule

// file: verif/bsf_operator.sv
// bsf_operator: operator at the programming and function buttons
// assumes the bench calls its tasks; pins move just after core_clk rises
`timescale 1ns/1ps
module bsf_operator (
    // clock
    input  wire logic core_clk,
    // raw buttons, high = pressed, low when let go
    output logic      prog_btn,
    output logic      func_btn
);
    // both buttons idle at time zero
    initial begin
        prog_btn = 1'b0;
        func_btn = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // drive one pin at the next rising edge
    task automatic drv(input bit sel_func, input logic v);
        @(posedge core_clk);
        if (sel_func) begin
            func_btn <= v;
        end else begin
            prog_btn <= v;
        end
    endtask

    // one press: contact bounce, then a steady hold of the given cycles
    task automatic press(input bit sel_func, input int unsigned hold);
        drv(sel_func, 1'b1);
        drv(sel_func, 1'b0);
        drv(sel_func, 1'b1);
        repeat (hold) @(posedge core_clk);
        drv(sel_func, 1'b0);
    endtask
endmodule

// file: verif/test_button_special_function_control.sv
// test_button_special_function_control: self-checking bench for bsf_ctrl
// assumes every count, debounce included, is shortened through the design
// parameters, so the whole run takes under two thousand cycles
`timescale 1ns/1ps
module test_button_special_function_control;
    import bsf_pkg::*;
    // shortened counts, all but the blink half period above the debounce time
    localparam int unsigned DB      = 20;
    localparam int unsigned SHORT_P = 50;
    localparam int unsigned LONG_P  = 200;
    localparam int unsigned TMO_P   = 300;
    localparam int unsigned LINK_P  = 40;
    localparam int unsigned BLK_P   = 10;
    localparam int unsigned H_TAP   = DB + 10;          // short tap
    localparam int unsigned H_MID   = SHORT_P + 10;     // three second class
    localparam int unsigned H_LONG  = LONG_P + 10;      // fifteen second class
    localparam int unsigned CEIL    = 20_000;           // hang limit, cycles

    // design signals
    logic      core_clk;
    logic      rst;
    logic      ce;
    logic      prog_btn;
    logic      func_btn;
    logic      dl_active;
    bsf_addr_t dl_addr;
    logic      update_req;
    logic      update_done;
    bsf_addr_t node_address;
    logic      prog_mode;
    logic      link_reset;
    logic      factory_reset;
    logic      restart;
    logic      boot_mode;
    bsf_leds_t leds;
    // bench bookkeeping
    int        err_total;
    int        num_checks;
    int        cyc;

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            err_total++;
            complete_run();
        end
    end

    bsf_ctrl #(.DB_CYC(DB), .SHORT_CYC(SHORT_P), .LONG_CYC(LONG_P), .TIMEOUT_CYC(TMO_P),
               .LINK_CYC(LINK_P), .BLINKH_CYC(BLK_P)) u_dut (
        .core_clk(core_clk), .rst(rst), .ce(ce), .prog_btn(prog_btn),
        .func_btn(func_btn), .dl_active(dl_active), .dl_addr(dl_addr),
        .update_req(update_req), .update_done(update_done),
        .node_address(node_address), .prog_mode(prog_mode),
        .link_reset(link_reset), .factory_reset(factory_reset),
        .restart(restart), .boot_mode(boot_mode), .leds(leds));

    bsf_operator u_op (.core_clk(core_clk), .prog_btn(prog_btn), .func_btn(func_btn));

    ////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // watched condition by code
    function automatic logic sig(input int w);
        case (w)
            1: return link_reset;
            2: return factory_reset;
            3: return boot_mode;
            4: return restart;
            default: return logic'(leds.led1 == BSF_LED_ORANGE);
        endcase
    endfunction

    // step one cycle, then wait for a condition under a bound
    task automatic wait_on(input int w, input int unsigned lim);
        int unsigned n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (sig(w) !== 1'b1 && n < lim);
    endtask

    task automatic settle();
        repeat (DB + 50) @(posedge core_clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        chk("addr", 16'hffff, node_address);
        chk("leds", 16'({BSF_LED_GREEN, BSF_LED_GREEN, BSF_LED_OFF}), 16'(leds));
        @(posedge core_clk);
        update_req <= 1'b1;
        @(posedge core_clk);
        update_req <= 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        chk("boot unauthorised", 16'h0, 16'(boot_mode));
    endtask

    task automatic t_prog_addr();
        @(posedge core_clk);
        dl_active <= 1'b1;
        dl_addr   <= 16'h1234;
        u_op.press(1'b0, H_TAP);
        settle();
        chk("prog on", 16'h1, 16'(prog_mode));
        chk("led7 red", 16'(BSF_LED_RED), 16'(leds.led7));
        chk("addr kept", 16'hffff, node_address);
        u_op.press(1'b0, H_TAP);
        settle();
        chk("addr stored", 16'h1234, node_address);
        chk("prog off", 16'h0, 16'(prog_mode));
        chk("led7 off", 16'(BSF_LED_OFF), 16'(leds.led7));
        dl_active <= 1'b0;
    endtask

    task automatic t_link();
        int unsigned n;
        u_op.press(1'b1, H_MID);
        wait_on(1, DB + 50);
        chk("link on", 16'h1, 16'(link_reset));
        chk("led2 orange", 16'(BSF_LED_ORANGE), 16'(leds.led2));
        n = 0;
        while (link_reset === 1'b1 && n < 1000) begin
            n++;
            @(posedge core_clk);
            #1;
        end
        chk("link cycles", 16'(LINK_P), 16'(n));
        chk("led2 green", 16'(BSF_LED_GREEN), 16'(leds.led2));
    endtask

    task automatic t_factory();
        u_op.press(1'b1, H_LONG);
        wait_on(5, DB + 50);
        chk("fr wait leds", 16'({BSF_LED_ORANGE, BSF_LED_ORANGE, BSF_LED_OFF}), 16'(leds));
        u_op.press(1'b1, H_MID);
        wait_on(2, DB + 50);
        chk("fr pulse", 16'h1, 16'(factory_reset));
        @(posedge core_clk);
        #1;
        chk("restart", 16'h1, 16'(restart));
        chk("addr default", 16'hffff, node_address);
        @(posedge core_clk);
        #1;
        chk("restart once", 16'h0, 16'(restart));
        chk("leds normal", 16'({BSF_LED_GREEN, BSF_LED_GREEN, BSF_LED_OFF}), 16'(leds));
    endtask

    task automatic t_abandon();
        u_op.press(1'b1, H_LONG);
        wait_on(5, DB + 50);
        chk("fr wait", 16'(BSF_LED_ORANGE), 16'(leds.led1));
        repeat (TMO_P + 50) @(posedge core_clk);
        #1;
        chk("abandoned leds", 16'({BSF_LED_GREEN, BSF_LED_GREEN, BSF_LED_OFF}), 16'(leds));
    endtask

    task automatic t_update();
        int unsigned g;
        u_op.press(1'b0, H_TAP);
        settle();
        u_op.press(1'b1, H_TAP);
        settle();
        chk("no boot yet", 16'h0, 16'(boot_mode));
        @(posedge core_clk);
        update_req <= 1'b1;
        @(posedge core_clk);
        update_req <= 1'b0;
        wait_on(3, 20);
        chk("boot", 16'h1, 16'(boot_mode));
        g = 0;
        repeat (2 * BLK_P) begin
            @(posedge core_clk);
            #1;
            if (leds.led2 === BSF_LED_GREEN) g++;
        end
        chk("blink green cycles", 16'(BLK_P), 16'(g));
        @(posedge core_clk);
        update_done <= 1'b1;
        @(posedge core_clk);
        update_done <= 1'b0;
        // restart stands for the one cycle after the done edge only
        #1;
        chk("update restart", 16'h1, 16'(restart));
        @(posedge core_clk);
        #1;
        chk("boot left", 16'h0, 16'(boot_mode));
    endtask

    ////////////////////////////////////////////////////////////////////////
    // verdict and main sequence
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        err_total   = 0;
        num_checks  = 0;
        cyc         = 0;
        rst         = 1'b1;
        ce          = 1'b1;
        dl_active   = 1'b0;
        dl_addr     = 16'h0;
        update_req  = 1'b0;
        update_done = 1'b0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        t_reset();
        t_prog_addr();
        t_link();
        t_factory();
        t_abandon();
        t_update();
        complete_run();
    end
endmodule
